// ==== logic/cpcap_pkg.sv ====
// constants and types for the continuous ping-pong capture block
package cpcap_pkg;

  // apb address width in bits
  localparam int ADDR_W = 18;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SW_BUF_CNT = 16'hea60;
  localparam logic [15:0] IDX_BUF_LEN = 16'hea6a;
  localparam logic [15:0] IDX_AVAIL = 16'hea88;
  localparam logic [15:0] IDX_CTRL = 16'hea90;
  localparam logic [15:0] IDX_STATUS = 16'hea91;
  localparam logic [15:0] IDX_RELEASE = 16'hea92;
  localparam logic [15:0] IDX_SEG_LEN = 16'hea93;
  localparam logic [15:0] IDX_MEM_SIZE = 16'hea94;
  localparam logic [15:0] IDX_POST_TRIG = 16'hea95;

  localparam logic [ADDR_W-1:0] ADR_SW_BUF_CNT = {IDX_SW_BUF_CNT, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_BUF_LEN = {IDX_BUF_LEN, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_AVAIL = {IDX_AVAIL, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_STATUS = {IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_RELEASE = {IDX_RELEASE, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_SEG_LEN = {IDX_SEG_LEN, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_MEM_SIZE = {IDX_MEM_SIZE, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_POST_TRIG = {IDX_POST_TRIG, 2'h0};

  // control register bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_SWTRIG = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_SEG = 3;
  localparam int CTRL_GATE = 4;

  // buffer length granularity (1024 bytes) and smallest buffer in words
  localparam logic [31:0] LEN_GRAIN_MASK = 32'h3ff;
  localparam logic [31:0] GRAIN_WORDS = 32'h200;

  // software buffer count reported to the host
  localparam logic [31:0] SW_BUF_MAX = 32'h100;

  // reset values
  localparam logic [31:0] SW_BUF_CNT_RST = 32'h2;
  localparam logic [31:0] BUF_LEN_RST = 32'h400;
  localparam logic [31:0] SEG_LEN_RST = 32'h400;

  // internal throughput figures: one 2-byte word per clock at most
  localparam int CLK_MHZ = 50;
  localparam int WORD_BYTES = 2;
  localparam int INT_TPUT_MBPS = 250;
  localparam int MAX_TPUT_MBPS = CLK_MHZ * WORD_BYTES;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_RUN = 2'b10,
    ST_HALT = 2'b11
  } cpcap_state_t;

endpackage

// ==== logic/cpcap_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module cpcap_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ==== logic/cpcap_top.sv ====
// continuous ping-pong capture into on-board sample memory, apb registers
`timescale 1ns/1ps
`default_nettype none
module cpcap_top
  import cpcap_pkg::*;
#(
  parameter int MEM_AW = 20
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter samples, pclk domain
  input wire logic sample_valid,
  input wire logic [11:0] sample_data,
  // asynchronous pins
  input wire logic trigger_pin,
  input wire logic gate_pin,
  // sample memory write port
  output logic mem_we,
  output logic [MEM_AW-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  // host notification and state
  output logic buf_full_irq,
  output logic run_active
);

  localparam logic [31:0] HALF_WORDS = 32'h1 << (MEM_AW - 1);

  cpcap_state_t state_r, state_nxt;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] sw_buf_cnt_r, buf_len_r, seg_len_r, mem_size_r, post_trig_r;
  logic seg_en_r, gate_en_r;
  logic buf_sel_r, overrun_r, trig_d_r, irq_r, run_r;
  logic [MEM_AW-1:0] wr_idx_r;
  logic [31:0] seg_cnt_r;
  logic [1:0] full_r;
  logic mem_we_r;
  logic [MEM_AW-1:0] mem_addr_r;
  logic [15:0] mem_wdata_r;
  wire logic [1:0] pin_s;
  wire logic trig_s = pin_s[1];
  wire logic gate_s = pin_s[0];

  cpcap_sync #(.W(2)) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({trigger_pin, gate_pin}),
    .q(pin_s)
  );

  // apb decode
  wire logic setup = psel & ~penable;
  wire logic wr_en = psel & penable & pready_r & pwrite;
  wire logic hit_cnt = (paddr == ADR_SW_BUF_CNT);
  wire logic hit_len = (paddr == ADR_BUF_LEN);
  wire logic hit_avail = (paddr == ADR_AVAIL);
  wire logic hit_ctrl = (paddr == ADR_CTRL);
  wire logic hit_stat = (paddr == ADR_STATUS);
  wire logic hit_rel = (paddr == ADR_RELEASE);
  wire logic hit_seg = (paddr == ADR_SEG_LEN);
  wire logic hit_msz = (paddr == ADR_MEM_SIZE);
  wire logic hit_post = (paddr == ADR_POST_TRIG);
  wire logic mapped = hit_cnt | hit_len | hit_avail | hit_ctrl | hit_stat
                    | hit_rel | hit_seg | hit_msz | hit_post;
  wire logic [31:0] ctrl_val = 32'h0 | ({31'h0, seg_en_r} << CTRL_SEG)
                             | ({31'h0, gate_en_r} << CTRL_GATE);
  wire logic [31:0] stat_val = {26'h0, overrun_r, full_r, buf_sel_r, state_r};
  wire logic [31:0] rd_val = hit_cnt ? sw_buf_cnt_r :
                             hit_len ? buf_len_r :
                             hit_avail ? SW_BUF_MAX :
                             hit_ctrl ? ctrl_val :
                             hit_stat ? stat_val :
                             hit_seg ? seg_len_r :
                             hit_msz ? mem_size_r :
                             hit_post ? post_trig_r : 32'h0;

  // command pulses
  wire logic ctrl_wr = wr_en & hit_ctrl;
  wire logic cmd_start = ctrl_wr & pwdata[CTRL_START];
  wire logic cmd_trig = ctrl_wr & pwdata[CTRL_SWTRIG];
  wire logic cmd_stop = ctrl_wr & pwdata[CTRL_STOP];
  wire logic [1:0] rel = {2{wr_en & hit_rel}} & pwdata[1:0];
  wire logic start_ok = cmd_start & ~cmd_stop & (state_r == ST_IDLE | state_r == ST_HALT);

  wire logic [31:0] len_words = {1'b0, buf_len_r[31:1]};
  wire logic [MEM_AW-1:0] buf_words = (len_words == 32'h0) ? GRAIN_WORDS[MEM_AW-1:0] :
                                      (len_words > HALF_WORDS) ? HALF_WORDS[MEM_AW-1:0] :
                                      len_words[MEM_AW-1:0];

  wire logic trig_hit = (trig_s & ~trig_d_r) | cmd_trig;
  wire logic gate_ok = ~gate_en_r | gate_s;
  wire logic seg_ok = ~seg_en_r | (seg_cnt_r != 32'h0);
  wire logic seg_done = (state_r == ST_RUN) & seg_en_r & (seg_cnt_r == 32'h0);
  wire logic acc = (state_r == ST_RUN) & sample_valid & gate_ok & seg_ok & ~cmd_stop;
  // write into a buffer not yet drained
  wire logic ovr = acc & full_r[buf_sel_r] & ~rel[buf_sel_r];
  wire logic wr_smp = acc & ~ovr;
  wire logic last = (wr_idx_r == buf_words - MEM_AW'(1));
  wire logic fill_end = wr_smp & last;
  // second buffer starts right after the first
  wire logic [MEM_AW-1:0] addr_nxt = buf_sel_r ? (buf_words + wr_idx_r) : wr_idx_r;
  wire logic [15:0] sext = {{4{sample_data[11]}}, sample_data};

  // apb answer: one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup)
        prdata_r <= pwrite ? 32'h0 : rd_val;
    end
  end

  // memory size and post-trigger only stored and read back, never used by capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_buf_cnt_r <= SW_BUF_CNT_RST;
      buf_len_r <= BUF_LEN_RST;
      seg_len_r <= SEG_LEN_RST;
      mem_size_r <= 32'h0;
      post_trig_r <= 32'h0;
      seg_en_r <= 1'b0;
      gate_en_r <= 1'b0;
    end
    else
    begin
      if (wr_en & hit_cnt)
        sw_buf_cnt_r <= pwdata;
      // low ten bits forced to zero
      if (wr_en & hit_len)
        buf_len_r <= pwdata & ~LEN_GRAIN_MASK;
      if (wr_en & hit_seg)
        seg_len_r <= pwdata;
      if (wr_en & hit_msz)
        mem_size_r <= pwdata;
      if (wr_en & hit_post)
        post_trig_r <= pwdata;
      if (ctrl_wr)
      begin
        seg_en_r <= pwdata[CTRL_SEG];
        gate_en_r <= pwdata[CTRL_GATE];
      end
    end
  end

  // acquisition sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_HALT:
        if (start_ok)
          state_nxt = ST_ARM;
      ST_ARM:
        if (cmd_stop)
          state_nxt = ST_IDLE;
        else if (trig_hit)
          state_nxt = ST_RUN;
      ST_RUN:
        if (cmd_stop)
          state_nxt = ST_IDLE;
        else if (ovr)
          state_nxt = ST_HALT;
        else if (seg_done)
          state_nxt = ST_ARM;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      trig_d_r <= 1'b0;
      irq_r <= 1'b0;
      run_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= '0;
      mem_wdata_r <= 16'h0;
    end
    else
    begin
      state_r <= state_nxt;
      trig_d_r <= trig_s;
      irq_r <= fill_end;
      run_r <= (state_nxt == ST_RUN);
      mem_we_r <= wr_smp;
      if (wr_smp)
      begin
        mem_addr_r <= addr_nxt;
        mem_wdata_r <= sext;
      end
    end
  end

  // circular recording until stopped or halted by an overrun
  // write pointer, buffer select, overrun and segment count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_sel_r <= 1'b0;
      wr_idx_r <= '0;
      overrun_r <= 1'b0;
      seg_cnt_r <= 32'h0;
    end
    else
    begin
      if (start_ok)
      begin
        buf_sel_r <= 1'b0;
        wr_idx_r <= '0;
        overrun_r <= 1'b0;
      end
      // swap buffers and wrap to the start
      else if (fill_end)
      begin
        buf_sel_r <= ~buf_sel_r;
        wr_idx_r <= '0;
      end
      else if (wr_smp)
        wr_idx_r <= wr_idx_r + MEM_AW'(1);
      if (ovr)
        overrun_r <= 1'b1;
      if (state_r == ST_ARM && trig_hit)
        seg_cnt_r <= seg_len_r;
      else if (wr_smp && seg_en_r)
        seg_cnt_r <= seg_cnt_r - 32'h1;
    end
  end

  // full flags per buffer; a new fill wins over a release
  for (genvar i = 0; i < 2; i++)
  begin : g_full
    wire logic set_i = fill_end & (buf_sel_r == 1'(i));
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        full_r[i] <= 1'b0;
      else if (start_ok)
        full_r[i] <= 1'b0;
      else
        full_r[i] <= set_i | (full_r[i] & ~rel[i]);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign buf_full_irq = irq_r;
  assign run_active = run_r;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_fill_end;
    wr_smp && last;
  endsequence

  sequence s_armed_trig;
    (state_r == ST_ARM) && trig_hit && !cmd_stop;
  endsequence

  property p_full_irq;
    s_fill_end |=> buf_full_irq && full_r[$past(buf_sel_r)];
  endproperty
  a_full_irq: assert property (p_full_irq) else $error("buffer fill without irq");

  property p_swap;
    s_fill_end ##0 !start_ok |=> (buf_sel_r != $past(buf_sel_r)) && (wr_idx_r == '0);
  endproperty
  a_swap: assert property (p_swap) else $error("no buffer swap after fill");

  property p_overrun_halt;
    ovr |=> (state_r == ST_HALT) && overrun_r && !mem_we_r;
  endproperty
  a_overrun_halt: assert property (p_overrun_halt) else $error("overrun not halted");

  property p_arm_start;
    s_armed_trig |=> (state_r == ST_RUN);
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("trigger did not start run");

  property p_no_rec_armed;
    (state_r == ST_ARM) |=> !mem_we_r;
  endproperty
  a_no_rec_armed: assert property (p_no_rec_armed) else $error("write while armed");

  property p_sext;
    mem_we |-> (mem_wdata[15:12] == {4{mem_wdata[11]}});
  endproperty
  a_sext: assert property (p_sext) else $error("sample not sign extended");

  property p_addr_bound;
    wr_smp |-> addr_nxt < {buf_words, 1'b0};
  endproperty
  a_addr_bound: assert property (p_addr_bound) else $error("write outside two buffers");

  property p_half;
    buf_words <= HALF_WORDS[MEM_AW-1:0];
  endproperty
  a_half: assert property (p_half) else $error("buffer above half memory");

  property p_len_grain;
    (buf_len_r & LEN_GRAIN_MASK) == 32'h0;
  endproperty
  a_len_grain: assert property (p_len_grain) else $error("length not 1024 multiple");

  property p_avail;
    setup && !pwrite && hit_avail |=> pready && (prdata == SW_BUF_MAX) ##1 !pready;
  endproperty
  a_avail: assert property (p_avail) else $error("wrong available count");

  property p_gate;
    (state_r == ST_RUN) && gate_en_r && !gate_s |=> !mem_we_r;
  endproperty
  a_gate: assert property (p_gate) else $error("sample written outside gate");

  property p_tput;
    mem_we |-> $past(sample_valid) && (MAX_TPUT_MBPS <= INT_TPUT_MBPS);
  endproperty
  a_tput: assert property (p_tput) else $error("write without accepted sample");

endmodule
`default_nettype wire

// ==== tb/cpcap_host.sv ====
// host driver model: apb master, buffer setup and buffer release
`timescale 1ns/1ps
`default_nettype none
module cpcap_host
  import cpcap_pkg::*;
(
  // clock
  input wire logic pclk,
  // apb master
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [ADDR_W-1:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end

  // one transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic setup(input logic [31:0] cnt, input logic [31:0] samples);
    wr(ADR_SW_BUF_CNT, cnt);
    wr(ADR_BUF_LEN, samples * 32'h2);
  endtask

  task automatic release_buf(input int b);
    wr(ADR_RELEASE, 32'h1 << b);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_continuous_pingpong_capture.sv ====
// testbench of the continuous ping-pong capture block
`timescale 1ns/1ps
`default_nettype none
module tb_continuous_pingpong_capture;
  import cpcap_pkg::*;
  localparam int AW = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, mem_we, buf_full_irq, run_active;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic sample_valid = 1'b0;
  logic [11:0] sample_data = 12'h0;
  logic trigger_pin = 1'b0;
  logic gate_pin = 1'b0;
  logic [AW-1:0] mem_addr, exp_addr;
  logic [15:0] mem_wdata;
  logic [11:0] last_s, sidx;
  int failures = 0;
  int cmp_count = 0;
  int wcount = 0;
  int icount = 0;
  int cyc = 0;
  int w0, i0;

  always #10 pclk = ~pclk;

  cpcap_top #(.MEM_AW(AW)) i_cpcap_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_data(sample_data), .trigger_pin(trigger_pin), .gate_pin(gate_pin),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .buf_full_irq(buf_full_irq), .run_active(run_active));

  cpcap_host i_cpcap_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // memory write monitor and cycle ceiling
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    last_s <= sample_data;
    if (mem_we === 1'b1)
    begin
      chk(32'(mem_wdata), 32'({{4{last_s[11]}}, last_s}));
      chk(32'(mem_addr), 32'(exp_addr));
      exp_addr <= exp_addr + 1'b1;
      wcount <= wcount + 1;
    end
    if (buf_full_irq === 1'b1)
    begin
      icount <= icount + 1;
      chk({22'h0, mem_we, mem_addr[8:0]}, 32'h3ff);
    end
    if (cyc > 20000)
    begin
      failures++;
      finish_test();
    end
  end

  // one sample per clock at most
  task automatic send(input int n);
    for (int i = 0; i < n; i++)
    begin
      sample_valid <= 1'b1;
      sample_data <= sidx;
      sidx = sidx + 12'h25;
      @(posedge pclk);
    end
    sample_valid <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic arm(input logic [31:0] opts);
    i_cpcap_host.wr(ADR_CTRL, opts | 32'h1);
    exp_addr = '0;
  endtask

  task automatic test_regs();
    i_cpcap_host.rd(ADR_SW_BUF_CNT, q, e);
    chk(q, 32'h2);
    i_cpcap_host.rd(ADR_BUF_LEN, q, e);
    chk(q, 32'h400);
    i_cpcap_host.wr(ADR_AVAIL, 32'h5);
    i_cpcap_host.rd(ADR_AVAIL, q, e);
    chk(q, 32'h100);
    chk({31'h0, e}, 32'h0);
    i_cpcap_host.wr(ADR_BUF_LEN, 32'h7ff);
    i_cpcap_host.rd(ADR_BUF_LEN, q, e);
    chk(q, 32'h400);
    i_cpcap_host.wr(ADR_SW_BUF_CNT, 32'h100);
    i_cpcap_host.rd(ADR_SW_BUF_CNT, q, e);
    chk(q, 32'h100);
    i_cpcap_host.rd('0, q, e);
    chk({31'h0, e}, 32'h1);
    $display("test regs done");
  endtask

  task automatic test_trigger();
    arm(32'h0);
    idle(6);
    chk({31'h0, run_active}, 32'h0);
    trigger_pin <= 1'b1;
    idle(6);
    chk({31'h0, run_active}, 32'h1);
    trigger_pin <= 1'b0;
    i_cpcap_host.wr(ADR_CTRL, 32'h4);
    idle(3);
    chk({31'h0, run_active}, 32'h0);
    $display("test trigger done");
  endtask

  task automatic test_gate();
    gate_pin <= 1'b0;
    arm(32'h10);
    i_cpcap_host.wr(ADR_CTRL, 32'h12);
    idle(3);
    w0 = wcount;
    send(4);
    idle(3);
    chk(32'(wcount - w0), 32'h0);
    gate_pin <= 1'b1;
    idle(5);
    send(4);
    idle(3);
    chk(32'(wcount - w0), 32'h4);
    i_cpcap_host.wr(ADR_CTRL, 32'h4);
    $display("test gate done");
  endtask

  task automatic test_segment();
    i_cpcap_host.wr(ADR_SEG_LEN, 32'h4);
    arm(32'h8);
    i_cpcap_host.wr(ADR_CTRL, 32'ha);
    idle(3);
    w0 = wcount;
    send(6);
    idle(3);
    chk(32'(wcount - w0), 32'h4);
    i_cpcap_host.rd(ADR_STATUS, q, e);
    chk(q & 32'h3, 32'h1);
    i_cpcap_host.wr(ADR_CTRL, 32'h4);
    $display("test segment done");
  endtask

  task automatic test_fill();
    i_cpcap_host.wr(ADR_POST_TRIG, 32'h1);
    i_cpcap_host.wr(ADR_MEM_SIZE, 32'h1);
    i_cpcap_host.setup(32'h2, 32'h200);
    arm(32'h0);
    i_cpcap_host.wr(ADR_CTRL, 32'h2);
    idle(3);
    w0 = wcount;
    i0 = icount;
    fork
      send(1536);
      begin
        wait (icount == i0 + 1);
        i_cpcap_host.release_buf(0);
      end
    join
    idle(3);
    chk(32'(wcount - w0), 32'd1536);
    chk(32'(icount - i0), 32'h3);
    chk({31'h0, run_active}, 32'h1);
    send(1);
    idle(3);
    chk(32'(wcount - w0), 32'd1536);
    chk({31'h0, run_active}, 32'h0);
    i_cpcap_host.rd(ADR_STATUS, q, e);
    chk(q & 32'h23, 32'h23);
    $display("test fill done");
  endtask

  initial
  begin
    sidx = 12'h7f0;
    exp_addr = '0;
    idle(3);
    presetn <= 1'b1;
    test_regs();
    test_trigger();
    test_gate();
    test_segment();
    test_fill();
    finish_test();
  end
endmodule
`default_nettype wire
